// ==== pxc_pkg.sv ====
package pxc_pkg;

    // register indices on the management port
    localparam logic [4:0]  PXC_ADDR_TBT  = 5'h12;        // ten_base_t_operations
    localparam logic [4:0]  PXC_ADDR_EXT  = 5'h13;        // extended_control_two

    // ten_base_t_operations field positions
    localparam int          PXC_TBT_SQUELCH   = 0;
    localparam int          PXC_TBT_LINKLOSS  = 1;
    localparam int          PXC_TBT_SQE       = 2;
    localparam int          PXC_TBT_POLARITY  = 3;
    localparam int          PXC_TBT_JABBER    = 5;
    localparam int          PXC_TBT_POLREV    = 14;
    localparam int          PXC_TBT_RJAB      = 15;
    localparam logic [15:0] PXC_TBT_RESET     = 16'h0010;  // reserved bit 4 defaults to 1
    localparam logic [15:0] PXC_TBT_RW_MASK   = 16'h3fff;  // writable bits

    // extended_control_two field positions
    localparam int          PXC_EXT_PWRDN     = 0;
    localparam int          PXC_EXT_TRI       = 7;
    localparam int          PXC_EXT_SWAP      = 8;
    localparam int          PXC_EXT_XAUTO     = 9;
    localparam int          PXC_EXT_RFAULT    = 13;
    localparam int          PXC_EXT_SWMODE    = 14;
    localparam int          PXC_EXT_NODE      = 15;
    localparam logic [15:0] PXC_EXT_RESET     = 16'h0201;  // xauto=1, swap=0, pwrdn=1
    localparam logic [15:0] PXC_EXT_RW_MASK   = 16'h1bff;  // bit 10 is read-only

    // sqe pulse timing
    localparam int          PXC_SQE_DELAY_NS  = 1000;      // quiet time after transmit ends
    localparam int          PXC_SQE_WIDTH_NS  = 1000;      // collision pulse width
    localparam int          PXC_CLK_NS        = 10;
    localparam int          PXC_SQE_DELAY_CYC = (PXC_SQE_DELAY_NS + PXC_CLK_NS - 1) / PXC_CLK_NS;
    localparam int          PXC_SQE_WIDTH_CYC = PXC_SQE_WIDTH_NS / PXC_CLK_NS;

    // management access group
    typedef struct packed {
        logic        wr;     // one-cycle write strobe
        logic        rd;     // one-cycle read strobe
        logic [4:0]  addr;   // register index
        logic [15:0] wdata;  // write data
    } pxc_mgmt_s;

    // line-side status fed from the analog front end
    typedef struct packed {
        logic tx_en;         // mac transmit enable
        logic rx_active;     // receive activity
        logic rx_valid;      // valid 10base-t data seen
        logic idle_seen;     // idle pattern seen
        logic link_pulse;    // receiver signalling present
        logic pol_reversed;  // receive pair polarity reversed
        logic rx_jabber;     // jabber seen on receive path
        logic auto_cross;    // auto crossover decision: 1 = cross
        logic partner_rf;    // remote fault from partner code word
        logic full_duplex;   // link runs full duplex
        logic speed_10;      // link runs 10base-t
        logic isolate;       // isolate control
    } pxc_line_s;

endpackage

// ==== pxc_sqe.sv ====
`timescale 1ns/1ns
`default_nettype none
module pxc_sqe
    import pxc_pkg::*;
#(
    parameter int DELAY_CYC = PXC_SQE_DELAY_CYC,
    parameter int WIDTH_CYC = PXC_SQE_WIDTH_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic tx_en,
    output var  logic pulse
);
    typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_PULSE} pxc_sqe_e;

    pxc_sqe_e    state;       // sequencer state
    pxc_sqe_e    next_state;
    logic [15:0] count;       // cycle counter
    logic [15:0] next_count;
    logic        tx_d;        // delayed transmit enable
    logic        next_pulse;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic: falling transmit enable starts wait then pulse
    always_comb begin
        next_state = state;
        next_count = count;
        next_pulse = 1'b0;
        unique case (state)
            SQ_IDLE: begin
                if (tx_d && !tx_en && enable) begin
                    next_state = SQ_WAIT;
                    next_count = 16'(DELAY_CYC - 1);
                end
            end
            SQ_WAIT: begin
                if (!enable || tx_en) begin
                    next_state = SQ_IDLE;
                end else if (count == 16'h0000) begin
                    next_state = SQ_PULSE;
                    next_count = 16'(WIDTH_CYC - 1);
                    next_pulse = 1'b1;
                end else begin
                    next_count = count - 16'h0001;
                end
            end
            SQ_PULSE: begin
                // inhibit or full duplex cuts a running pulse short
                if (!enable || count == 16'h0000) begin
                    next_state = SQ_IDLE;
                end else begin
                    next_count = count - 16'h0001;
                    next_pulse = 1'b1;
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= SQ_IDLE;
            count <= 16'h0000;
            tx_d  <= 1'b0;
            pulse <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            tx_d  <= tx_en;
            pulse <= next_pulse;
        end
    end
endmodule // pxc_sqe
`default_nettype wire

// ==== pxc_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module pxc_ctrl
    import pxc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire pxc_pkg::pxc_mgmt_s mgmt,
    input  wire pxc_pkg::pxc_line_s line,
    input  wire logic              strap_xauto,
    output var  logic [15:0]       rdata,
    output var  logic              col,
    output var  logic              crs,
    output var  logic              link_ok,
    output var  logic              pol_correct,
    output var  logic              tx_on_pair_b,
    output var  logic              tx_pair_oe,
    output var  logic              tx100_power_down,
    output var  logic              jabber_check_en
);
    import pxc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [15:0] tbt;            // ten_base_t_operations writable part
    logic [15:0] next_tbt;
    logic [15:0] ext;            // extended_control_two writable part
    logic [15:0] next_ext;
    logic        rjab;           // latched remote jabber
    logic        next_rjab;
    logic        polrev;         // latched polarity reversed
    logic        next_polrev;
    logic [15:0] next_rdata;

    // read decode for the read data; the latch clear decodes the address on its own
    function automatic logic [15:0] read_word(input logic [4:0] a, input logic [15:0] t, input logic [15:0] e,
                                              input logic rj, input logic pr, input logic rf);
        logic [15:0] w;
        w = 16'h0000;
        if (a == PXC_ADDR_TBT) begin
            w = t & PXC_TBT_RW_MASK;
            w[PXC_TBT_RJAB]   = rj;
            w[PXC_TBT_POLREV] = pr;
        end else if (a == PXC_ADDR_EXT) begin
            w = e & PXC_EXT_RW_MASK;
            w[PXC_EXT_NODE]   = 1'b0;
            w[PXC_EXT_SWMODE] = 1'b1;
            w[PXC_EXT_RFAULT] = rf;
        end
        return w;
    endfunction

    // register next values; reserved bits hold what was written, except extended_control_two bit 10
    always_comb begin
        next_tbt    = tbt;
        next_ext    = ext;
        next_rjab   = rjab;
        next_polrev = polrev;
        if (mgmt.wr && mgmt.addr == PXC_ADDR_TBT) begin
            next_tbt = mgmt.wdata & PXC_TBT_RW_MASK;
        end
        if (mgmt.wr && mgmt.addr == PXC_ADDR_EXT) begin
            next_ext = mgmt.wdata & PXC_EXT_RW_MASK;
        end
        // latching bits: clear on read, a new event wins
        if (mgmt.rd && mgmt.addr == PXC_ADDR_TBT) begin
            next_rjab   = 1'b0;
            next_polrev = 1'b0;
        end
        if (line.rx_jabber) begin
            next_rjab = 1'b1;
        end
        if (line.pol_reversed) begin
            next_polrev = 1'b1;
        end
        next_rdata = rdata;
        if (mgmt.rd) begin
            next_rdata = read_word(mgmt.addr, tbt, ext, rjab, polrev, line.partner_rf);
        end
    end

    // register flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tbt    <= PXC_TBT_RESET;
            ext    <= PXC_EXT_RESET;
            rjab   <= 1'b0;
            polrev <= 1'b0;
            rdata  <= 16'h0000;
        end else begin
            tbt    <= next_tbt;
            ext    <= next_ext;
            rjab   <= next_rjab;
            polrev <= next_polrev;
            rdata  <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sqe test generator
    logic sqe_en;     // sqe allowed
    logic sqe_pulse;  // collision test pulse

    // inhibit bit, or full duplex, suppresses; bit itself untouched
    assign sqe_en = !tbt[PXC_TBT_SQE] && !line.full_duplex;

    pxc_sqe u_sqe (
        .clk    (clk),
        .rst_n  (rst_n),
        .enable (sqe_en),
        .tx_en  (line.tx_en),
        .pulse  (sqe_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // 10base-t link integrity
    typedef enum logic [1:0] {LK_FAIL, LK_DATA, LK_PASS} pxc_link_e;

    pxc_link_e link_state;  // link integrity state
    pxc_link_e next_link;

    // squelch inhibit needs idle after data; link-loss inhibit forces pass
    always_comb begin
        next_link = link_state;
        if (tbt[PXC_TBT_LINKLOSS]) begin
            next_link = LK_PASS;
        end else begin
            unique case (link_state)
                LK_FAIL: begin
                    if (line.rx_valid) begin
                        next_link = tbt[PXC_TBT_SQUELCH] ? LK_DATA : LK_PASS;
                    end
                end
                LK_DATA: begin
                    if (!line.link_pulse) begin
                        next_link = LK_FAIL;
                    end else if (line.idle_seen) begin
                        next_link = LK_PASS;
                    end
                end
                LK_PASS: begin
                    if (!line.link_pulse) begin
                        next_link = LK_FAIL;
                    end
                end
                default: next_link = LK_FAIL;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_state <= LK_FAIL;
        end else begin
            link_state <= next_link;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line-side outputs
    logic next_col;
    logic next_crs;
    logic next_link_ok;
    logic next_pol;
    logic next_cross;
    logic next_oe;
    logic next_pd;
    logic next_jab;

    always_comb begin
        next_col     = sqe_pulse;
        next_crs     = line.tx_en || line.rx_active;
        next_link_ok = (next_link == LK_PASS);
        next_pol     = !tbt[PXC_TBT_POLARITY];
        if (!strap_xauto) begin
            next_cross = 1'b0;
        end else if (ext[PXC_EXT_XAUTO]) begin
            next_cross = line.auto_cross;
        end else begin
            next_cross = ext[PXC_EXT_SWAP];
        end
        if (!ext[PXC_EXT_XAUTO]) begin
            next_cross = ext[PXC_EXT_SWAP];
        end
        next_oe      = !ext[PXC_EXT_TRI];
        next_pd      = (ext[PXC_EXT_PWRDN] && line.speed_10)
                       || line.isolate;
        next_jab     = !tbt[PXC_TBT_JABBER];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            col              <= 1'b0;
            crs              <= 1'b0;
            link_ok          <= 1'b0;
            pol_correct      <= 1'b1;
            tx_on_pair_b     <= 1'b0;
            tx_pair_oe       <= 1'b1;
            tx100_power_down <= 1'b0;
            jabber_check_en  <= 1'b1;
        end else begin
            col              <= next_col;
            crs              <= next_crs;
            link_ok          <= next_link_ok;
            pol_correct      <= next_pol;
            tx_on_pair_b     <= next_cross;
            tx_pair_oe       <= next_oe;
            tx100_power_down <= next_pd;
            jabber_check_en  <= next_jab;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_strap_low;
        @(posedge clk) disable iff (!rst_n) (!strap_xauto && ext[PXC_EXT_XAUTO]) |=> !tx_on_pair_b;
    endproperty
    a_strap_low: assert property (p_strap_low) else $error("strap low must give straight");

    property p_manual;
        @(posedge clk) disable iff (!rst_n) !ext[PXC_EXT_XAUTO] |=> (tx_on_pair_b == $past(ext[PXC_EXT_SWAP]));
    endproperty
    a_manual: assert property (p_manual) else $error("manual swap not followed");

    property p_auto;
        @(posedge clk) disable iff (!rst_n) (strap_xauto && ext[PXC_EXT_XAUTO]) |=> (tx_on_pair_b == $past(line.auto_cross));
    endproperty
    a_auto: assert property (p_auto) else $error("auto crossover not followed");

    property p_sqe_off;
        @(posedge clk) disable iff (!rst_n) (tbt[PXC_TBT_SQE] || line.full_duplex) [*3] |=> !col;
    endproperty
    a_sqe_off: assert property (p_sqe_off) else $error("sqe pulse while suppressed");

    ////////////////////////////////////////////////////////////////////////
    // assertion helper: quiet cycles since transmit ended with sqe allowed
    logic        tx_prev;       // transmit enable one cycle back
    logic        next_tx_prev;
    logic [15:0] tx_gap;        // 0 while no sqe wait is running
    logic [15:0] next_tx_gap;

    // counts on its own, so the sequencer's wait length is really checked
    always_comb begin
        next_tx_prev = line.tx_en;
        next_tx_gap  = 16'h0000;
        if (tx_prev && !line.tx_en && sqe_en) begin
            next_tx_gap = 16'h0001;
        end else if (tx_gap != 16'h0000 && tx_gap != 16'(PXC_SQE_DELAY_CYC) && sqe_en && !line.tx_en) begin
            next_tx_gap = tx_gap + 16'h0001;
        end
    end

    // helper flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_prev <= 1'b0;
            tx_gap  <= 16'h0000;
        end else begin
            tx_prev <= next_tx_prev;
            tx_gap  <= next_tx_gap;
        end
    end

    sequence s_tx_quiet;
        tx_gap == 16'(PXC_SQE_DELAY_CYC) && sqe_en && !line.tx_en;
    endsequence
    property p_sqe_pulse;
        @(posedge clk) disable iff (!rst_n) s_tx_quiet |-> ##[1:4] col;
    endproperty
    a_sqe_pulse: assert property (p_sqe_pulse) else $error("sqe pulse missing");

    property p_link_forced;
        @(posedge clk) disable iff (!rst_n) tbt[PXC_TBT_LINKLOSS] |=> link_ok;
    endproperty
    a_link_forced: assert property (p_link_forced) else $error("link not forced pass");

    property p_crs;
        @(posedge clk) disable iff (!rst_n) (line.tx_en || line.rx_active) |=> crs;
    endproperty
    a_crs: assert property (p_crs) else $error("carrier sense missing");

    property p_tri;
        @(posedge clk) disable iff (!rst_n) ext[PXC_EXT_TRI] |=> !tx_pair_oe;
    endproperty
    a_tri: assert property (p_tri) else $error("transmit pair not tristated");

    property p_pd;
        @(posedge clk) disable iff (!rst_n)
            ((ext[PXC_EXT_PWRDN] && line.speed_10) || line.isolate) |=> tx100_power_down;
    endproperty
    a_pd: assert property (p_pd) else $error("100base-tx not powered down");

    property p_ro_bits;
        @(posedge clk) disable iff (!rst_n) (mgmt.rd && mgmt.addr == PXC_ADDR_EXT)
            |=> (rdata[PXC_EXT_NODE] == 1'b0 && rdata[PXC_EXT_SWMODE] == 1'b1
                 && rdata[PXC_EXT_RFAULT] == $past(line.partner_rf));
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("fixed status bits wrong");

endmodule // pxc_ctrl
`default_nettype wire

// ==== pxc_sta_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// station management model: one-cycle strobes launched at the falling edge
module pxc_sta_model (
    input  wire logic               clk,
    output var  pxc_pkg::pxc_mgmt_s mgmt
);
    import pxc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // reserved positions of each register
    localparam logic [15:0] TBT_RSV = 16'h3fd0;  // bits 13:6 and 4
    localparam logic [15:0] EXT_RSV = 16'h1c7e;  // bits 12:10 and 6:1

    // idle bus until the first request
    initial begin
        mgmt = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // write one register; reserved bits always carry their defaults
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == PXC_ADDR_TBT) begin
            v = (d & ~TBT_RSV) | (PXC_TBT_RESET & TBT_RSV);
        end
        if (a == PXC_ADDR_EXT) begin
            v = (d & ~EXT_RSV) | (PXC_EXT_RESET & EXT_RSV);
        end
        @(negedge clk);
        mgmt = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge clk);
        // released lines show the inverse, never a stale copy
        mgmt = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    endtask

    // read one register; data is judged by the bench monitor
    task automatic rd_reg(input logic [4:0] a);
        @(negedge clk);
        mgmt = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~mgmt.wdata};
        @(negedge clk);
        mgmt = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~mgmt.wdata};
    endtask
endmodule // pxc_sta_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pxc_pkg::*;

    logic                 clk;               // 100 MHz clock
    logic                 rst_n;             // sync reset
    pxc_mgmt_s            mgmt;              // register port
    pxc_line_s            line_i;            // line-side status
    logic                 strap;             // crossover strap pin
    logic [15:0]          rdata;             // read data
    logic                 col;               // collision
    logic                 crs;               // carrier sense
    logic                 link_ok;           // link passed
    logic                 pol_correct;       // polarity correction on
    logic                 tx_on_pair_b;      // cross wiring
    logic                 tx_pair_oe;        // transmit pair drive
    logic                 tx100_power_down;  // 100base-tx off
    logic                 jabber_check_en;   // jabber check on
    int                   miscompares;       // mismatch count
    int                   n_checks;          // comparison count
    logic [15:0]          exp_q[$];          // expected read data
    logic [15:0]          w;                 // random write word

    ////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        clk = 1'b0;
    end
    always #5 clk = ~clk;

    pxc_sta_model sta_u (.clk(clk), .mgmt(mgmt));

    pxc_ctrl dut_u (
        .clk(clk), .rst_n(rst_n), .mgmt(mgmt), .line(line_i), .strap_xauto(strap),
        .rdata(rdata), .col(col), .crs(crs), .link_ok(link_ok), .pol_correct(pol_correct),
        .tx_on_pair_b(tx_on_pair_b), .tx_pair_oe(tx_pair_oe),
        .tx100_power_down(tx100_power_down), .jabber_check_en(jabber_check_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // note the expectation, then read
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        sta_u.rd_reg(a);
    endtask

    // let a write reach the outputs
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask

    // expected read of the extended register
    function automatic logic [15:0] ext_rd(input logic [15:0] v, input logic rf);
        return (v & 16'h0381) | 16'h4000 | {2'b00, rf, 13'h0000};
    endfunction

    // one frame, then watch the collision output
    task automatic sqe_run(input logic exp);
        int rise;
        int width;
        rise = -1;
        width = 0;
        line_i.tx_en = 1'b1;
        settle();
        check("crs", crs, 1'b1);
        line_i.tx_en = 1'b0;
        for (int t = 1; t <= 300; t++) begin
            @(negedge clk);
            if (col === 1'b1) begin
                if (rise < 0) rise = t;
                width++;
            end
        end
        if (exp) begin
            check("sqe_delay", 16'(rise >= PXC_SQE_DELAY_CYC && rise <= PXC_SQE_DELAY_CYC + 4), 1'b1);
            check("sqe_width", 16'(width), 16'(PXC_SQE_WIDTH_CYC));
        end else begin
            check("sqe_width", 16'(width), 16'h0000);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // read monitor: oldest note against the answer one cycle later
    always @(posedge clk) begin
        if (mgmt.rd === 1'b1) begin
            @(negedge clk);
            check("rdata", rdata, exp_q.pop_front());
        end
    end

    // watchdog
    initial begin
        #(20000 * 10);
        miscompares++;
        $display("watchdog expired");
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        miscompares = 0;
        n_checks = 0;
        rst_n = 1'b0;
        strap = 1'b1;
        line_i = '0;
        line_i.link_pulse = 1'b1;
        void'($urandom(32'h912c));
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        // reset state
        check("pol_correct", pol_correct, 1'b1);
        check("tx_pair_oe", tx_pair_oe, 1'b1);
        check("tx_on_pair_b", tx_on_pair_b, 1'b0);
        check("link_ok", link_ok, 1'b0);
        rd(PXC_ADDR_TBT, PXC_TBT_RESET);
        rd(PXC_ADDR_EXT, 16'h4201);
        $display("test reset done");
        // every strap, auto and swap combination with random data
        for (int i = 0; i < 16; i++) begin
            w = (16'($urandom) & 16'hfc7f) | {6'd0, i[1], i[2], 8'd0};
            strap = i[0];
            line_i.auto_cross = i[3];
            line_i.partner_rf = 1'($urandom_range(1, 0));
            sta_u.wr_reg(PXC_ADDR_EXT, w);
            settle();
            check("tx_on_pair_b", tx_on_pair_b, i[1] ? (i[0] & i[3]) : i[2]);
            rd(PXC_ADDR_EXT, ext_rd(w, line_i.partner_rf));
        end
        $display("test crossover done");
        // tristate and power-down
        sta_u.wr_reg(PXC_ADDR_EXT, 16'h0281);
        settle();
        check("tx_pair_oe", tx_pair_oe, 1'b0);
        check("tx100_power_down", tx100_power_down, 1'b0);
        line_i.speed_10 = 1'b1;
        settle();
        check("tx100_power_down", tx100_power_down, 1'b1);
        sta_u.wr_reg(PXC_ADDR_EXT, 16'h0000);
        settle();
        check("tx_pair_oe", tx_pair_oe, 1'b1);
        check("tx100_power_down", tx100_power_down, 1'b0);
        check("pol_correct", pol_correct, 1'b1);
        line_i.isolate = 1'b1;
        settle();
        check("tx100_power_down", tx100_power_down, 1'b1);
        line_i.isolate = 1'b0;
        line_i.speed_10 = 1'b0;
        // unmapped place
        sta_u.wr_reg(5'h05, 16'hffff);
        rd(5'h05, 16'h0000);
        rd(PXC_ADDR_EXT, ext_rd(16'h0000, line_i.partner_rf));
        $display("test power done");
        // latched reversal, polarity and jabber controls
        line_i.pol_reversed = 1'b1;
        line_i.rx_jabber = 1'b1;
        @(negedge clk);
        line_i.pol_reversed = 1'b0;
        line_i.rx_jabber = 1'b0;
        rd(PXC_ADDR_TBT, 16'hc010);
        rd(PXC_ADDR_TBT, 16'h0010);
        sta_u.wr_reg(PXC_ADDR_TBT, 16'h0028);
        settle();
        check("pol_correct", pol_correct, 1'b0);
        check("jabber_check_en", jabber_check_en, 1'b0);
        rd(PXC_ADDR_TBT, 16'h0038);
        $display("test polarity done");
        // sqe: enabled, inhibited, full duplex
        sta_u.wr_reg(PXC_ADDR_TBT, 16'h0010);
        sqe_run(1'b1);
        check("crs", crs, 1'b0);
        line_i.rx_active = 1'b1;
        settle();
        check("crs", crs, 1'b1);
        line_i.rx_active = 1'b0;
        sta_u.wr_reg(PXC_ADDR_TBT, 16'h0014);
        sqe_run(1'b0);
        sta_u.wr_reg(PXC_ADDR_TBT, 16'h0010);
        line_i.full_duplex = 1'b1;
        sqe_run(1'b0);
        rd(PXC_ADDR_TBT, 16'h0010);
        line_i.full_duplex = 1'b0;
        $display("test sqe done");
        // link integrity and squelch
        line_i.rx_valid = 1'b1;
        @(negedge clk);
        line_i.rx_valid = 1'b0;
        settle();
        check("link_ok", link_ok, 1'b1);
        line_i.link_pulse = 1'b0;
        settle();
        check("link_ok", link_ok, 1'b0);
        sta_u.wr_reg(PXC_ADDR_TBT, 16'h0012);
        settle();
        check("link_ok", link_ok, 1'b1);
        sta_u.wr_reg(PXC_ADDR_TBT, 16'h0011);
        settle();
        check("link_ok", link_ok, 1'b0);
        line_i.link_pulse = 1'b1;
        line_i.rx_valid = 1'b1;
        @(negedge clk);
        line_i.rx_valid = 1'b0;
        settle();
        check("link_ok", link_ok, 1'b0);
        line_i.idle_seen = 1'b1;
        @(negedge clk);
        line_i.idle_seen = 1'b0;
        settle();
        check("link_ok", link_ok, 1'b1);
        $display("test link done");
        // mid-run reset brings the crossover defaults back
        sta_u.wr_reg(PXC_ADDR_EXT, 16'h0100);
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        check("link_ok", link_ok, 1'b0);
        check("tx_on_pair_b", tx_on_pair_b, 1'b0);
        rd(PXC_ADDR_EXT, ext_rd(16'h0201, line_i.partner_rf));
        $display("test reset again done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
